// *** logic/scl_latch.sv ***
// one-shot capture of the strap levels after reset release
`include "scl_params.svh"

module scl_latch
  import scl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  scl_strap_if.latch sif
);

  logic       captured_r, captured_nxt;
  logic [2:0] addr_r,     addr_nxt;
  logic [2:0] mode_r,     mode_nxt;
  logic       neg_r,      neg_nxt;
  logic       nand_r,     nand_nxt;
  logic       filt_r,     filt_nxt;

  // ----------------------------------------
  // capture logic
  // ----------------------------------------
  always_comb begin
    captured_nxt = captured_r;
    addr_nxt     = addr_r;
    mode_nxt     = mode_r;
    neg_nxt      = neg_r;
    nand_nxt     = nand_r;
    filt_nxt     = filt_r;
    if (!captured_r) begin
      captured_nxt = 1'b1;
      addr_nxt = {sif.pin_lvl[`SCL_PIN_ADDR2], sif.pin_lvl[`SCL_PIN_ADDR1],
                  sif.pin_lvl[`SCL_PIN_ADDR0]};
      mode_nxt = {sif.pin_lvl[`SCL_PIN_MODE2], sif.pin_lvl[`SCL_PIN_MODE1],
                  sif.pin_lvl[`SCL_PIN_MODE0]};
      neg_nxt  = sif.pin_lvl[`SCL_PIN_NEG];
      nand_nxt = sif.pin_lvl[`SCL_PIN_NAND];
      filt_nxt = sif.pin_lvl[`SCL_PIN_FILT];
    end
  end

  // reset values mirror the internal pulls
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      captured_r <= 1'b0;
      addr_r     <= `SCL_RST_ADDR;
      mode_r     <= `SCL_RST_MODE;
      neg_r      <= `SCL_RST_NEG;
      nand_r     <= `SCL_RST_NAND;
      filt_r     <= `SCL_RST_FILT;
    end else begin
      captured_r <= captured_nxt;
      addr_r     <= addr_nxt;
      mode_r     <= mode_nxt;
      neg_r      <= neg_nxt;
      nand_r     <= nand_nxt;
      filt_r     <= filt_nxt;
    end
  end

  assign sif.captured = captured_r;
  assign sif.addr_lo  = addr_r;
  assign sif.mode     = mode_r;
  assign sif.neg_dis  = neg_r;
  assign sif.nand_n   = nand_r;
  assign sif.filt_dis = filt_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_addr_bits: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(captured_r) |-> addr_r[1] == $past(sif.pin_lvl[`SCL_PIN_ADDR1])
      && addr_r[2] == $past(sif.pin_lvl[`SCL_PIN_ADDR2]))
    else $error("address strap bits mapped wrong");
  a_strap_hold: assert property (@(posedge clk_sys) disable iff (reset)
    captured_r && $past(captured_r) |-> $stable(addr_r) && $stable(mode_r)
      && $stable(neg_r) && $stable(nand_r) && $stable(filt_r))
    else $error("latched strap changed after capture");

endmodule : scl_latch

// *** logic/scl_top.sv ***
// strap configuration latch with shared pins and register access
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`include "scl_params.svh"

module scl_top
  import scl_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // shared strap pins
  input  wire logic [`SCL_NPINS-1:0] strap_pin_in,
  output logic [`SCL_NPINS-1:0]      strap_pin_out,
  output logic [`SCL_NPINS-1:0]      strap_pin_oe_n,
  // receive side from the core
  input  wire logic [1:0]            rx_data_in,
  input  wire logic                  rx_valid_in,
  input  wire logic                  rx_error_in,
  // transmit side from the mac
  input  wire logic                  tx_enable,
  input  wire logic [1:0]            tx_data_in,
  output logic [1:0]                 tx_data,
  output logic                       tx_valid,
  // event request toward the open-drain pin
  input  wire logic                  event_request_out,
  // latched configuration
  output logic [4:0]                 mgmt_station_address,
  output logic                       back_to_back_mode,
  output logic                       crossover_enable,
  output logic                       mode_reserved,
  output logic                       negotiation_disable,
  output logic                       nand_tree_mode,
  output logic                       filter_enable,
  output logic                       strap_done
);

  // ----------------------------------------
  // strap latch
  // ----------------------------------------
  scl_strap_if sif ();

  assign sif.pin_lvl = strap_pin_in;

  scl_latch u_latch (
    .clk_sys (clk_sys),
    .reset   (reset),
    .sif     (sif)
  );

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  logic        ctrl_neg_r,    ctrl_neg_nxt;
  logic        ctrl_filt_r,   ctrl_filt_nxt;
  logic [4:0]  addr_out_r,    addr_out_nxt;
  logic        b2b_r,         b2b_nxt;
  logic        xover_r,       xover_nxt;
  logic        resv_r,        resv_nxt;
  logic        nand_r,        nand_nxt;
  logic [31:0] wdata_r,       wdata_nxt;
  logic [3:0]  s_axi_wstrb_r, wstrb_nxt;
  logic        wr_fire;
  logic        wr_ctrl;

  always_comb begin
    ctrl_neg_nxt  = ctrl_neg_r;
    ctrl_filt_nxt = ctrl_filt_r;
    if (wr_ctrl && s_axi_wstrb_r[`SCL_LANE_NEG]) begin
      ctrl_neg_nxt = wdata_r[`SCL_CT_NEG];
    end
    if (wr_ctrl && s_axi_wstrb_r[`SCL_LANE_FILT]) begin
      ctrl_filt_nxt = wdata_r[`SCL_CT_FILT];
    end
    // strap load wins over a write
    if (!sif.captured) begin
      ctrl_neg_nxt  = strap_pin_in[`SCL_PIN_NEG];
      ctrl_filt_nxt = strap_pin_in[`SCL_PIN_FILT];
    end
    addr_out_nxt = {`SCL_ADDR_UPPER, sif.addr_lo};
    b2b_nxt   = scl_mode_of(sif.mode) == SCL_MODE_B2B;
    xover_nxt = scl_xover_of(sif.mode);
    resv_nxt  = scl_mode_of(sif.mode) == SCL_MODE_RESV;
    nand_nxt  = !sif.nand_n;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_neg_r  <= `SCL_RST_NEG;
      ctrl_filt_r <= `SCL_RST_FILT;
      addr_out_r  <= {`SCL_ADDR_UPPER, `SCL_RST_ADDR};
      b2b_r       <= 1'b0;
      xover_r     <= 1'b0;
      resv_r      <= 1'b1;
      nand_r      <= !`SCL_RST_NAND;
    end else begin
      ctrl_neg_r  <= ctrl_neg_nxt;
      ctrl_filt_r <= ctrl_filt_nxt;
      addr_out_r  <= addr_out_nxt;
      b2b_r       <= b2b_nxt;
      xover_r     <= xover_nxt;
      resv_r      <= resv_nxt;
      nand_r      <= nand_nxt;
    end
  end

  assign mgmt_station_address = addr_out_r;
  assign back_to_back_mode    = b2b_r;
  assign crossover_enable     = xover_r;
  assign mode_reserved        = resv_r;
  assign negotiation_disable  = ctrl_neg_r;
  assign nand_tree_mode       = nand_r;
  // low strap or control bit enables filter
  assign filter_enable        = !ctrl_filt_r;
  assign strap_done           = sif.captured;

  // ----------------------------------------
  // shared pin drivers
  // ----------------------------------------
  logic [1:0] rxd_r,  rxd_nxt;
  logic       rxdv_r, rxdv_nxt;
  logic       rxer_r, rxer_nxt;
  logic       evt_r,  evt_nxt;
  logic [1:0] txd_r,  txd_nxt;
  logic       txv_r,  txv_nxt;

  always_comb begin
    rxd_nxt  = rx_valid_in ? rx_data_in : 2'h0;
    rxdv_nxt = rx_valid_in;
    rxer_nxt = rx_valid_in & rx_error_in;
    evt_nxt  = event_request_out;
    txd_nxt  = tx_enable ? tx_data_in : txd_r;
    txv_nxt  = tx_enable;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxd_r  <= 2'h0;
      rxdv_r <= 1'b0;
      rxer_r <= 1'b0;
      evt_r  <= 1'b0;
      txd_r  <= 2'h0;
      txv_r  <= 1'b0;
    end else begin
      rxd_r  <= rxd_nxt;
      rxdv_r <= rxdv_nxt;
      rxer_r <= rxer_nxt;
      evt_r  <= evt_nxt;
      txd_r  <= txd_nxt;
      txv_r  <= txv_nxt;
    end
  end

  assign tx_data  = txd_r;
  assign tx_valid = txv_r;

  // unused pins drive low; event pin is open drain, pulling low only
  always_comb begin
    strap_pin_out                 = '0;
    strap_pin_out[`SCL_PIN_ADDR2] = rxd_r[1];
    strap_pin_out[`SCL_PIN_NEG]   = rxd_r[0];
    strap_pin_out[`SCL_PIN_MODE2] = rxdv_r;
    strap_pin_out[`SCL_PIN_FILT]  = rxer_r;
    strap_pin_oe_n                = sif.captured ? '0 : '1;
    strap_pin_oe_n[`SCL_PIN_NAND] = !(sif.captured && evt_r);
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic              aw_got_r, aw_got_nxt;
  logic              w_got_r,  w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r,  bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r,  rresp_nxt;
  logic [31:0]       rdata_r,  rdata_nxt;

  function automatic scl_sel_t sel_of(input logic [ADDR_W-1:0] a);
    scl_sel_t s;
    s = SCL_SEL_NONE;
    if (a == ADDR_W'(`SCL_OFS_STATUS)) begin
      s = SCL_SEL_STATUS;
    end else if (a == ADDR_W'(`SCL_OFS_CTRL)) begin
      s = SCL_SEL_CTRL;
    end
    return s;
  endfunction : sel_of

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_fire       = aw_got_r && w_got_r && !bvalid_r;
  assign wr_ctrl       = wr_fire && sel_of(awaddr_r) == SCL_SEL_CTRL;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = s_axi_wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // status is read-only, so writes to it are refused too
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_ctrl ? `SCL_RESP_OKAY : `SCL_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `SCL_RESP_OKAY;
      rdata_nxt  = '0;
      case (sel_of(s_axi_araddr))
        SCL_SEL_STATUS: begin
          rdata_nxt[`SCL_ST_ADDR +: 5] = addr_out_r;
          rdata_nxt[`SCL_ST_MODE +: 3] = sif.mode;
          rdata_nxt[`SCL_ST_NEG]       = sif.neg_dis;
          rdata_nxt[`SCL_ST_NAND]      = sif.nand_n;
          rdata_nxt[`SCL_ST_FILT]      = sif.filt_dis;
          rdata_nxt[`SCL_ST_RESV]      = resv_r;
          rdata_nxt[`SCL_ST_B2B]       = b2b_r;
          rdata_nxt[`SCL_ST_XOVER]     = xover_r;
          rdata_nxt[`SCL_ST_DONE]      = sif.captured;
        end
        SCL_SEL_CTRL: begin
          rdata_nxt[`SCL_CT_NEG]  = ctrl_neg_r;
          rdata_nxt[`SCL_CT_FILT] = ctrl_filt_r;
        end
        default: begin
          rresp_nxt = `SCL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      s_axi_wstrb_r <= '0;
      bvalid_r      <= 1'b0;
      bresp_r       <= `SCL_RESP_OKAY;
      rvalid_r      <= 1'b0;
      rresp_r       <= `SCL_RESP_OKAY;
      rdata_r       <= '0;
    end else begin
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      s_axi_wstrb_r <= wstrb_nxt;
      bvalid_r      <= bvalid_nxt;
      bresp_r       <= bresp_nxt;
      rvalid_r      <= rvalid_nxt;
      rresp_r       <= rresp_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pins_float: assert property (@(posedge clk_sys) disable iff (reset)
    !strap_done |-> &strap_pin_oe_n)
    else $error("strap pin driven before capture");
  a_pins_drive: assert property (@(posedge clk_sys) disable iff (reset)
    strap_done |-> strap_pin_oe_n[`SCL_PIN_ADDR2] == 1'b0)
    else $error("shared pin not driven after capture");
  a_addr_form: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(strap_done) |=> mgmt_station_address
      == {`SCL_ADDR_UPPER, $past(strap_pin_in[`SCL_PIN_ADDR2:`SCL_PIN_ADDR0], 2)})
    else $error("management address not formed from straps");
  a_mode_decode: assert property (@(posedge clk_sys) disable iff (reset)
    strap_done && $past(strap_done) |-> crossover_enable
      == (sif.mode == `SCL_CODE_B2B || sif.mode == `SCL_CODE_NORM_X)
      && back_to_back_mode == (sif.mode == `SCL_CODE_B2B))
    else $error("mode code decoded wrong");
  a_neg_load: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(strap_done) |-> negotiation_disable == $past(strap_pin_in[`SCL_PIN_NEG]))
    else $error("negotiation bit not loaded from strap");
  a_nand_mode: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(strap_done) |=> nand_tree_mode == !$past(strap_pin_in[`SCL_PIN_NAND], 2))
    else $error("test mode strap not applied");
  a_filt_load: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(strap_done) |-> filter_enable == !$past(strap_pin_in[`SCL_PIN_FILT]))
    else $error("filter strap not applied");
  a_rx_gate: assert property (@(posedge clk_sys) disable iff (reset)
    !rx_valid_in |=> rxd_r == 2'h0 && !rxdv_r)
    else $error("receive data present without valid");
  a_tx_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !tx_enable |=> !tx_valid && $stable(tx_data))
    else $error("transmit data taken without enable");

endmodule : scl_top

// *** shared/scl_params.svh ***
// constants for the strap configuration latch
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// ----------------------------------------
// strap pin indices
// ----------------------------------------
`define SCL_NPINS      9
`define SCL_PIN_ADDR0  0
`define SCL_PIN_ADDR1  1
`define SCL_PIN_ADDR2  2
`define SCL_PIN_NEG    3
`define SCL_PIN_MODE2  4
`define SCL_PIN_MODE1  5
`define SCL_PIN_MODE0  6
`define SCL_PIN_NAND   7
`define SCL_PIN_FILT   8

// ----------------------------------------
// strap defaults and codes
// ----------------------------------------
`define SCL_ADDR_UPPER   2'h0
`define SCL_RST_ADDR     3'h1
`define SCL_RST_MODE     3'h0
`define SCL_RST_NEG      1'h1
`define SCL_RST_NAND     1'h1
`define SCL_RST_FILT     1'h0
`define SCL_CODE_NORM    3'h1
`define SCL_CODE_B2B     3'h5
`define SCL_CODE_NORM_X  3'h7

// ----------------------------------------
// register map
// ----------------------------------------
`define SCL_OFS_STATUS   4'h0
`define SCL_OFS_CTRL     4'h4
`define SCL_ST_ADDR      0
`define SCL_ST_MODE      5
`define SCL_ST_NEG       8
`define SCL_ST_NAND      9
`define SCL_ST_FILT      10
`define SCL_ST_RESV      11
`define SCL_ST_B2B       12
`define SCL_ST_XOVER     13
`define SCL_ST_DONE      14
`define SCL_CT_FILT      1
`define SCL_CT_NEG       12
`define SCL_LANE_FILT    0
`define SCL_LANE_NEG     1
`define SCL_RESP_OKAY    2'h0
`define SCL_RESP_SLVERR  2'h2

`endif

// *** shared/scl_pkg.sv ***
// types and decode helpers for the strap configuration latch
`include "scl_params.svh"

package scl_pkg;

  typedef enum {SCL_MODE_RESV, SCL_MODE_NORMAL, SCL_MODE_B2B} scl_mode_t;
  typedef enum {SCL_SEL_STATUS, SCL_SEL_CTRL, SCL_SEL_NONE}   scl_sel_t;

  function automatic scl_mode_t scl_mode_of(input logic [2:0] code);
    scl_mode_t m;
    m = SCL_MODE_RESV;
    if (code == `SCL_CODE_NORM || code == `SCL_CODE_NORM_X) begin
      m = SCL_MODE_NORMAL;
    end else if (code == `SCL_CODE_B2B) begin
      m = SCL_MODE_B2B;
    end
    return m;
  endfunction : scl_mode_of

  function automatic logic scl_xover_of(input logic [2:0] code);
    return (code == `SCL_CODE_B2B) || (code == `SCL_CODE_NORM_X);
  endfunction : scl_xover_of

endpackage : scl_pkg

// *** shared/scl_strap_if.sv ***
// strap levels in, latched configuration out
`include "scl_params.svh"

interface scl_strap_if;
  logic [`SCL_NPINS-1:0] pin_lvl;
  logic                  captured;
  logic [2:0]            addr_lo;
  logic [2:0]            mode;
  logic                  neg_dis;
  logic                  nand_n;
  logic                  filt_dis;

  modport latch (input pin_lvl, output captured, addr_lo, mode, neg_dis, nand_n, filt_dis);
  modport user  (output pin_lvl, input captured, addr_lo, mode, neg_dis, nand_n, filt_dis);
endinterface : scl_strap_if

// *** sim/scl_mac_model.sv ***
// mac-side model driving the transmit pins
module scl_mac_model (
  input  wire logic       clk_sys,
  input  wire logic       send,
  input  wire logic [7:0] frame,
  output logic            tx_enable,
  output logic [1:0]      tx_data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  int idx = 4;

  initial begin
    tx_enable  = 1'b0;
    tx_data_in = 2'h0;
  end

  // ----------------------------------------
  // transmit stream
  // ----------------------------------------
  // dibits move on the clock, enable marks them
  // idle data toggles so a held value cannot pass by luck
  // no shared strap pin is driven from this side at all
  always @(posedge clk_sys) begin
    if (idx < 4) begin
      tx_enable  <= 1'b1;
      tx_data_in <= frame[2*idx +: 2];
      idx        <= idx + 1;
    end else begin
      tx_enable  <= 1'b0;
      tx_data_in <= ~tx_data_in;
      if (send) begin
        idx <= 0;
      end
    end
  end
endmodule : scl_mac_model

// *** sim/strap_config_latch_tb.sv ***
// self-checking bench for the strap configuration latch
`include "scl_params.svh"

module strap_config_latch_tb
  import scl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [8:0]  strap_lvl = 9'h089;
  logic [8:0]  strap_pin_in, strap_pin_out, strap_pin_oe_n;
  logic [1:0]  rx_data_in = 2'h0;
  logic        rx_valid_in = 1'b0, rx_error_in = 1'b0, event_request_out = 1'b0;
  logic        send = 1'b0, tx_enable, tx_valid;
  logic [1:0]  tx_data_in, tx_data;
  logic [4:0]  mgmt_station_address;
  logic        back_to_back_mode, crossover_enable, mode_reserved;
  logic        negotiation_disable, nand_tree_mode, filter_enable, strap_done;
  logic [7:0]  frame = 8'h9C;
  int          compares = 0;
  int          miscompares = 0;

  always #10 clk_sys = ~clk_sys;

  // undriven pins sit at the resistor level, so reset sees the straps
  assign strap_pin_in = (strap_pin_oe_n & strap_lvl) | (~strap_pin_oe_n & strap_pin_out);

  scl_top i_scl_top (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .strap_pin_in(strap_pin_in),
    .strap_pin_out(strap_pin_out), .strap_pin_oe_n(strap_pin_oe_n),
    .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_error_in(rx_error_in),
    .tx_enable(tx_enable), .tx_data_in(tx_data_in), .tx_data(tx_data), .tx_valid(tx_valid),
    .event_request_out(event_request_out), .mgmt_station_address(mgmt_station_address),
    .back_to_back_mode(back_to_back_mode), .crossover_enable(crossover_enable),
    .mode_reserved(mode_reserved), .negotiation_disable(negotiation_disable),
    .nand_tree_mode(nand_tree_mode), .filter_enable(filter_enable), .strap_done(strap_done));

  scl_mac_model i_scl_mac_model (.clk_sys(clk_sys), .send(send), .frame(frame),
    .tx_enable(tx_enable), .tx_data_in(tx_data_in));

  // ----------------------------------------
  // reporting and bus helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    miscompares++;
    $display("Error %s expected answer seen none", what);
    complete_run();
  endtask : hang

  // sampling at the falling edge avoids racing the handshake edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int   n;
    logic ta, tw, tb;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang("write");
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta, tr;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang("read");
  endtask : axi_rd

  function automatic logic [31:0] stat(input logic [8:0] l);
    logic [2:0] c;
    logic       b, x, v;
    c = {l[4], l[5], l[6]};
    b = (c == 3'h5);
    x = (c == 3'h5) || (c == 3'h7);
    v = !(c == 3'h1 || x);
    return {17'h0, 1'b1, x, b, v, l[8], l[7], l[3], c, 2'h0, l[2:0]};
  endfunction : stat

  task automatic check_cfg(input logic [8:0] l);
    logic [31:0] e;
    e = stat(l);
    chk("address", mgmt_station_address, e[4:0]);
    chk("b2b", back_to_back_mode, e[12]);
    chk("xover", crossover_enable, e[13]);
    chk("reserved", mode_reserved, e[11]);
    chk("neg", negotiation_disable, l[3]);
    chk("nand", nand_tree_mode, !l[7]);
    chk("filter", filter_enable, !l[8]);
    chk("done", strap_done, 1'b1);
  endtask : check_cfg

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic strap_case(input logic [8:0] l);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_sys);
    strap_lvl <= l;
    reset     <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("oe in reset", strap_pin_oe_n, 9'h1FF);
    @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("oe after", strap_pin_oe_n, 9'h080);
    check_cfg(l);
    axi_rd(4'h0, d, r);
    chk("status", d, stat(l));
    axi_rd(4'h4, d, r);
    chk("ctrl", d, {19'h0, l[3], 10'h0, l[8], 1'b0});
    strap_lvl <= ~l;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check_cfg(l);
    $display("test strap %0h done", l);
  endtask : strap_case

  task automatic rx_case();
    @(posedge clk_sys);
    rx_data_in  <= 2'h2;
    rx_valid_in <= 1'b1;
    rx_error_in <= 1'b1;
    @(posedge clk_sys);
    rx_data_in  <= 2'h3;
    rx_valid_in <= 1'b0;
    rx_error_in <= 1'b0;
    @(negedge clk_sys);
    chk("rx on", {strap_pin_out[8], strap_pin_out[4], strap_pin_out[2], strap_pin_out[3]},
        4'hE);
    @(negedge clk_sys);
    chk("rx off", {strap_pin_out[8], strap_pin_out[4], strap_pin_out[2], strap_pin_out[3]},
        4'h0);
    $display("test rx done");
  endtask : rx_case

  task automatic tx_case();
    int k;
    @(posedge clk_sys);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("tx dibit", {tx_valid, tx_data}, {1'b1, frame[2*k +: 2]});
    end
    @(negedge clk_sys);
    chk("tx idle", {tx_valid, tx_data}, {1'b0, frame[7:6]});
    $display("test tx done");
  endtask : tx_case

  task automatic event_case();
    @(posedge clk_sys);
    event_request_out <= 1'b1;
    @(posedge clk_sys);
    event_request_out <= 1'b0;
    @(negedge clk_sys);
    chk("event low", {strap_pin_oe_n[7], strap_pin_out[7]}, 2'h0);
    @(negedge clk_sys);
    chk("event idle", strap_pin_oe_n[7], 1'b1);
    $display("test event done");
  endtask : event_case

  task automatic axi_case(input logic [8:0] l);
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(4'h4, 32'h0, 4'h2, r);
    chk("ctrl wr resp", r, `SCL_RESP_OKAY);
    chk("neg by sw", {negotiation_disable, filter_enable}, 2'h0);
    axi_wr(4'h4, 32'h1000, 4'h1, r);
    axi_rd(4'h4, d, r);
    chk("ctrl lanes", d, 32'h0);
    chk("filter by sw", filter_enable, 1'b1);
    axi_wr(4'h0, 32'hFFFFFFFF, 4'hF, r);
    chk("status wr", r, `SCL_RESP_SLVERR);
    axi_rd(4'h0, d, r);
    chk("status kept", d, stat(l));
    axi_rd(4'h8, d, r);
    chk("unmapped rd", d, 32'h0);
    chk("unmapped rd resp", r, `SCL_RESP_SLVERR);
    axi_wr(4'hC, 32'h1, 4'hF, r);
    chk("unmapped wr", r, `SCL_RESP_SLVERR);
    $display("test axi done");
  endtask : axi_case

  initial begin
    logic [8:0] l;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    strap_case(9'h089);
    for (int c = 0; c < 8; c++) begin
      l = {c[0], ~c[1], c[0], c[1], c[2], c[2], c[2:0]};
      strap_case(l);
    end
    rx_case();
    @(negedge clk_sys);
    check_cfg(l);
    tx_case();
    event_case();
    axi_case(l);
    complete_run();
  end
endmodule : strap_config_latch_tb
